// ==== hdl/spdi_top.sv ====
// Chosen here: the strobed register port.
`timescale 1ns/10ps

// ==========================================
// Receive event buffer
module spdi_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 4
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data,
	output logic o_full,
	output logic o_empty
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
	logic [AW:0] cnt_ff, nxt_cnt;
	logic push, pop;

	// Pointer step with wrap at depth
	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	// Handshake and next pointers
	always_comb begin
		o_full = (cnt_ff == DEPTH_C);
		o_empty = (cnt_ff == '0);
		o_in_ready = !o_full;
		o_out_valid = !o_empty;
		push = i_in_valid && o_in_ready;
		pop = o_out_valid && i_out_ready;
		nxt_wp = push ? ptr_inc(wp_ff) : wp_ff;
		nxt_rp = pop ? ptr_inc(rp_ff) : rp_ff;
		nxt_cnt = cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
		o_out_data = mem_ff[rp_ff];
	end

	// Pointer and storage registers
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end else begin
			wp_ff <= nxt_wp;
			rp_ff <= nxt_rp;
			cnt_ff <= nxt_cnt;
		end
		if (push) begin
			mem_ff[wp_ff] <= i_in_data;
		end
	end

	a_fifo_no_overfill: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		cnt_ff <= DEPTH_C) else $error("fifo count beyond depth");
endmodule

// ==========================================
// Serial pin control and data inversion
module spdi_top (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire spdi_pkg::spdi_bus_s i_bus,
	output logic [7:0] o_rdata,
	input wire logic i_tx_core,
	output logic o_rx_core,
	input wire logic i_port_out,
	input wire logic i_port_oe,
	output logic o_port_in,
	input wire logic i_pin_in,
	output logic o_pin_out,
	output logic o_pin_oe,
	input wire logic i_rx_pin,
	output logic o_rx_evt_valid,
	input wire logic i_rx_evt_ready,
	output logic o_rx_evt_level
);
	import spdi_pkg::*;

	spdi_ctrl_s ctrl_ff, nxt_ctrl;
	logic [7:0] rdata_ff, nxt_rdata;
	logic [2:0] rx_sync_ff, nxt_rx_sync;
	logic [2:0] pin_sync_ff, nxt_pin_sync;
	logic rx_lvl_ff, nxt_rx_lvl;
	logic port_in_ff, nxt_port_in;
	logic pend_ff, nxt_pend;
	logic pend_lvl_ff, nxt_pend_lvl;
	logic fifo_ready, fifo_full, fifo_empty;
	logic [0:0] fifo_out;

	// Address match helper
	function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
		hit = (a == b);
	endfunction

	// Register writes and read data
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_rdata = 8'h00;
		if (i_bus.wr && hit(i_bus.addr, SPDI_CTRL_ADDR)) begin
			nxt_ctrl.tx_sel = i_bus.wdata[SPDI_TX_SEL_BIT];
			nxt_ctrl.tx_inv = i_bus.wdata[SPDI_TX_INV_BIT];
			nxt_ctrl.rx_inv = i_bus.wdata[SPDI_RX_INV_BIT];
		end
		if (i_bus.rd && hit(i_bus.addr, SPDI_CTRL_ADDR)) begin
			nxt_rdata[7:6] = SPDI_TOP_BITS;
			nxt_rdata[SPDI_TX_SEL_BIT] = ctrl_ff.tx_sel;
			nxt_rdata[SPDI_TX_INV_BIT] = ctrl_ff.tx_inv;
			nxt_rdata[SPDI_RX_INV_BIT] = ctrl_ff.rx_inv;
		end else if (i_bus.rd && hit(i_bus.addr, SPDI_STAT_ADDR)) begin
			nxt_rdata[SPDI_STAT_RX_BIT] = rx_lvl_ff;
			nxt_rdata[SPDI_STAT_FULL_BIT] = fifo_full;
			nxt_rdata[SPDI_STAT_EMPTY_BIT] = fifo_empty;
		end
	end

	// Control and read registers
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			ctrl_ff <= spdi_ctrl_s'(SPDI_CTRL_RESET);
			rdata_ff <= 8'h00;
		end else begin
			ctrl_ff <= nxt_ctrl;
			rdata_ff <= nxt_rdata;
		end
	end
	assign o_rdata = rdata_ff;

	always_comb begin
		o_pin_out = ctrl_ff.tx_sel ? (i_tx_core ^ ctrl_ff.tx_inv) : i_port_out;
		o_pin_oe = ctrl_ff.tx_sel ? 1'b1 : i_port_oe;
	end

	assign o_rx_core = i_rx_pin ^ ctrl_ff.rx_inv;

	// Pin synchronisers and receive change capture
	always_comb begin
		nxt_rx_sync = {rx_sync_ff[1:0], i_rx_pin};
		nxt_pin_sync = {pin_sync_ff[1:0], i_pin_in};
		nxt_rx_lvl = rx_lvl_ff;
		nxt_port_in = port_in_ff;
		nxt_pend = pend_ff;
		nxt_pend_lvl = pend_lvl_ff;
		if (rx_sync_ff[1] == rx_sync_ff[2]) begin
			nxt_rx_lvl = rx_sync_ff[2] ^ ctrl_ff.rx_inv;
		end
		if (pin_sync_ff[1] == pin_sync_ff[2]) begin
			nxt_port_in = pin_sync_ff[2];
		end
		// Hold one change until the buffer accepts it
		if (pend_ff && fifo_ready) begin
			nxt_pend = 1'b0;
		end
		if (nxt_rx_lvl != rx_lvl_ff && !(pend_ff && !fifo_ready)) begin
			nxt_pend = 1'b1;
			nxt_pend_lvl = nxt_rx_lvl;
		end
	end

	// Synchroniser and capture registers
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			// Receive stages start at line idle, so leaving reset logs no false change
			rx_sync_ff <= {3{SPDI_RX_IDLE}};
			pin_sync_ff <= 3'h0;
			rx_lvl_ff <= SPDI_RX_IDLE;
			port_in_ff <= 1'b0;
			pend_ff <= 1'b0;
			pend_lvl_ff <= 1'b0;
		end else begin
			rx_sync_ff <= nxt_rx_sync;
			pin_sync_ff <= nxt_pin_sync;
			rx_lvl_ff <= nxt_rx_lvl;
			port_in_ff <= nxt_port_in;
			pend_ff <= nxt_pend;
			pend_lvl_ff <= nxt_pend_lvl;
		end
	end
	assign o_port_in = port_in_ff;

	// Buffer of received level changes
	spdi_fifo #(.WIDTH(SPDI_FIFO_WIDTH), .DEPTH(SPDI_FIFO_DEPTH)) u_fifo (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_in_valid(pend_ff),
		.o_in_ready(fifo_ready),
		.i_in_data(pend_lvl_ff),
		.o_out_valid(o_rx_evt_valid),
		.i_out_ready(i_rx_evt_ready),
		.o_out_data(fifo_out),
		.o_full(fifo_full),
		.o_empty(fifo_empty)
	);
	assign o_rx_evt_level = fifo_out[0];

	// ==========================================
	// Checks
	a_ctrl_write_held: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_bus.wr && i_bus.addr == SPDI_CTRL_ADDR) |=>
		(ctrl_ff.tx_sel == $past(i_bus.wdata[5]) && ctrl_ff.tx_inv == $past(i_bus.wdata[3])
		&& ctrl_ff.rx_inv == $past(i_bus.wdata[2]))) else $error("control write not stored");
	a_read_only_once: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!$past(i_bus.rd) |-> o_rdata == 8'h00) else $error("read data outside its cycle");
	a_ctrl_top_ones: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_bus.rd && i_bus.addr == SPDI_CTRL_ADDR) |=> (o_rdata[7:6] == 2'h3 && o_rdata[4] == 1'b0
		&& o_rdata[1:0] == 2'h0)) else $error("fixed bits wrong on read");
	a_ctrl_reset_zero: assert property (@(posedge i_clk_sys)
		i_rst |=> (ctrl_ff == 3'h0 && o_pin_oe == i_port_oe)) else $error("control not cleared by reset");
	a_pin_port_mode: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!ctrl_ff.tx_sel |-> (o_pin_out == i_port_out && o_pin_oe == i_port_oe)) else $error("port mode wrong");
	a_tx_inverted: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		ctrl_ff.tx_sel |-> (o_pin_oe && o_pin_out == (i_tx_core != ctrl_ff.tx_inv))) else $error("tx pin data wrong");
	a_rx_inverted: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		o_rx_core == (i_rx_pin != ctrl_ff.rx_inv)) else $error("rx core data wrong");
	a_rx_no_delay: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		($changed(i_rx_pin) && $stable(ctrl_ff.rx_inv)) |-> $changed(o_rx_core)) else $error("rx path delayed");
endmodule

// ==== hdl/spdi_pkg.sv ====
package spdi_pkg;
	// ==========================================
	// Register map
	localparam logic [15:0] SPDI_CTRL_ADDR = 16'hFF91;
	localparam logic [15:0] SPDI_STAT_ADDR = 16'hFF92;
	// ==========================================
	// Control field positions
	localparam int SPDI_TX_SEL_BIT = 5;
	localparam int SPDI_TX_INV_BIT = 3;
	localparam int SPDI_RX_INV_BIT = 2;
	localparam logic [1:0] SPDI_TOP_BITS = 2'h3;
	localparam logic [2:0] SPDI_CTRL_RESET = 3'h0;
	localparam logic SPDI_RX_IDLE = 1'h1; // Receive line rests high
	// ==========================================
	// Status field positions
	localparam int SPDI_STAT_RX_BIT = 0;
	localparam int SPDI_STAT_FULL_BIT = 1;
	localparam int SPDI_STAT_EMPTY_BIT = 2;
	// ==========================================
	// Receive event buffer
	localparam int SPDI_FIFO_WIDTH = 1;
	localparam int SPDI_FIFO_DEPTH = 4;
	// ==========================================
	// Carriers
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} spdi_bus_s;
	typedef struct packed {
		logic tx_sel;
		logic tx_inv;
		logic rx_inv;
	} spdi_ctrl_s;
endpackage

// ==== sim/spdi_line_model.sv ====
`timescale 1ns/10ps
// ==========================================
// Far end of the serial line and the shared pin wire
module spdi_line_model (
	input wire logic i_frame,
	input wire logic i_bit,
	input wire logic i_pin_oe,
	input wire logic i_pin_out,
	output logic o_rx_pin,
	output logic o_wire
);
	// line idles high
	// Line rests at the pull-up level between frames
	assign o_rx_pin = i_frame ? i_bit : 1'h1;
	// Shared pin pulled up when nobody drives it
	assign o_wire = i_pin_oe ? i_pin_out : 1'h1;
endmodule

// ==== sim/spdi_top_test.sv ====
`timescale 1ns/10ps
// ==========================================
// Self-checking bench for pin control and inversion
module spdi_top_test;
	import spdi_pkg::*;
	logic clk = 0, rst = 1, tx = 0, poe = 0, pout = 0, frame = 0, dbit = 0, rdy = 1;
	logic rxc, pin_out, pin_oe, port_in, evt_v, evt_l, rxp, wire_lvl;
	logic [7:0] o_rdata, rdata, v;
	logic [31:0] seed = 32'h62F9C384;
	spdi_bus_s bus = '0;
	int errors = 0, cmp_count = 0, cyc = 0, k, n;
	spdi_top spdi_top_i (.i_clk_sys(clk), .i_rst(rst), .i_bus(bus), .o_rdata(o_rdata), .i_tx_core(tx),
		.o_rx_core(rxc), .i_port_out(pout), .i_port_oe(poe), .o_port_in(port_in), .i_pin_in(wire_lvl),
		.o_pin_out(pin_out), .o_pin_oe(pin_oe), .i_rx_pin(rxp), .o_rx_evt_valid(evt_v),
		.i_rx_evt_ready(rdy), .o_rx_evt_level(evt_l));
	spdi_line_model spdi_line_model_i (.i_frame(frame), .i_bit(dbit), .i_pin_oe(pin_oe),
		.i_pin_out(pin_out), .o_rx_pin(rxp), .o_wire(wire_lvl));
	// Clock at 40 MHz
	initial begin
		forever #12.5 clk = ~clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Control read image: top bits one, bit four reads zero
	function automatic logic [7:0] ctrl_exp(input logic [7:0] w);
		return {SPDI_TOP_BITS, w[5], 1'h0, w[3], w[2], 2'h0};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
		@(posedge clk) bus.wr <= 1'h0;
	endtask
	task automatic rd(input logic [15:0] a);
		@(posedge clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
		@(posedge clk) bus.rd <= 1'h0;
		#1 rdata = o_rdata;
	endtask
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			errors++;
			finish_test();
		end
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		rd(SPDI_CTRL_ADDR);
		chk(rdata, 8'hC0, "ctrl reset");
		wr(SPDI_CTRL_ADDR, 8'h00);
		rd(SPDI_CTRL_ADDR);
		chk(rdata, 8'hC0, "top bits");
		rd(16'hFF90);
		chk(rdata, 8'h00, "unmapped read");
		$display("Test register reset done");
		// Random and corner control values, pin paths checked under each
		for (k = 0; k < 18; k++) begin
			seed = lfsr(seed);
			v = (k == 0) ? 8'hEC : (k == 1) ? 8'h00 : seed[7:0] & 8'hEC;
			wr(SPDI_CTRL_ADDR, v);
			rd(SPDI_CTRL_ADDR);
			chk(rdata, ctrl_exp(v), "ctrl readback");
			for (n = 0; n < 4; n++) begin
				seed = lfsr(seed);
				@(posedge clk) {tx, pout, poe, dbit} <= seed[3:0];
				frame <= 1'h1;
				#1 chk({7'h0, rxc}, {7'h0, dbit ^ v[2]}, "rx path");
				chk({7'h0, pin_out}, {7'h0, v[5] ? tx ^ v[3] : pout}, "tx path");
				chk({7'h0, pin_oe}, {7'h0, v[5] | poe}, "pin enable");
			end
			@(posedge clk) frame <= 1'h0;
			// Shared pin level seen through the three-stage synchroniser
			repeat (4) @(posedge clk);
			#1 chk({7'h0, port_in}, {7'h0, (v[5] | poe) ? (v[5] ? tx ^ v[3] : pout) : 1'h1}, "port input");
		end
		$display("Test control and pin paths done");
		wr(SPDI_CTRL_ADDR, 8'h00);
		// Let any change from the inversion switch drain before the stall
		repeat (8) @(posedge clk);
		@(posedge clk) rdy <= 1'h0;
		dbit <= 1'h1;
		frame <= 1'h1;
		// Six line changes into a four-deep buffer with the consumer stalled
		for (k = 0; k < 6; k++) begin
			repeat (8) @(posedge clk);
			dbit <= ~dbit;
		end
		repeat (12) @(posedge clk);
		rd(SPDI_STAT_ADDR);
		// Status bit zero shows the line level, high after six toggles
		chk(rdata & 8'h07, 8'h03, "buffer full");
		for (k = 0; k < 4; k++) begin
			chk({7'h0, evt_v}, 8'h01, "event valid");
			chk({7'h0, evt_l}, {7'h0, k[0]}, "event level");
			@(posedge clk) rdy <= 1'h1;
			@(posedge clk) rdy <= 1'h0;
			#1;
		end
		@(posedge clk) rdy <= 1'h1;
		repeat (20) @(posedge clk);
		rd(SPDI_STAT_ADDR);
		chk(rdata & 8'h07, 8'h05, "buffer empty");
		$display("Test event buffer done");
		finish_test();
	end
endmodule
